/* rtl/phylsr_top.sv */
// lane status, idle power-down and signal detect register bank on wishbone
//
// What this block does
// (R1) margin config status bit reads 1 when programmed offset unsupported
// (R2) margin result field reports 0 not run, 1-12 error ratio decades
// (R3) lane detect, polarity, lock, align, error bits read 0 when idle
// (R4) status bit 1 shows current receive polarity, 1 means reversed
// (R5) bit 2 shows clock recovery lock, bit 3 equalization completed
// (R6) bit 4 symbol alignment achieved, bit 5 training errors on lane
// (R7) self-test error ratio field shown when supported and enabled
// (R8) requested remote pre, post and swing cursor codes per lane
// (R9) bit 28 shows remote equalization change being requested
// (R10) detect control: 0 auto, 2 force none, 3 force detected
// (R11) polarity control: 0 normal, 1 inverted, 2 automatic default
// (R12) five bit peaking field in 1 dB steps, code 0 reserved
// (R13) full power down bit writable only over local sideband
// (R14) software clears power down before enabling; status shows mode
// (R15) capability reports power down exit latency code
// (R16) signal detect status is OR of all lane detect results
// (R17) signal detect error when detected but no width resolved
// (R18) signal detect reversal bit shows lane reversal detected
// (R19) writing 1 to write-only force bit forces signal detected
// (R20) send, idle and transition timers programmable with defaults
// (R21) header repeat count and header frequency programmable
// (R22) bit 11 selects scrambler reset by detect headers
// (R23) reserved status bits read zero, reserved control bits preserved
`timescale 1ns/1ps

module phylsr_top
  import phylsr_pkg::*;
#(
  parameter logic       FPD_SUPPORT = 1'b1,
  parameter logic [1:0] FPD_EXIT    = 2'h0,
  parameter logic [2:0] MRG_SUPPORT = 3'h0
)(
  // clock and reset
  input  wire logic                           clk_sys_in,
  input  wire logic                           resetn_in,
  // wishbone slave
  input  wire logic                           wb_cyc_in,
  input  wire logic                           wb_stb_in,
  input  wire logic                           wb_we_in,
  input  wire logic [AW-1:0]                  wb_adr_in,
  input  wire logic [3:0]                     wb_sel_in,
  input  wire logic [31:0]                    wb_dat_in,
  output logic      [31:0]                    wb_dat_out,
  output logic                                wb_ack_out,
  // access origin and link state
  input  wire logic                           sideband_in,
  input  wire logic [3:0]                     phy_state_in,
  input  wire logic                           selftest_en_in,
  input  wire logic                           sd_reached_in,
  input  wire logic                           sd_width_fail_in,
  input  wire logic                           sd_reversal_in,
  // lane receive logic
  input  wire phylsr_lane_in_t [LANES-1:0]    lane_in,
  output phylsr_lane_cfg_t     [LANES-1:0]    lane_cfg_out,
  // signal detect and power down settings
  output phylsr_detect_cfg_t                  detect_cfg_out,
  output logic                                power_down_out
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [31:0] margin_q    [LANES];
  logic [31:0] ctrl_q      [LANES];
  logic [31:0] status_q    [LANES];
  logic [15:0] idle_ctrl_q;
  logic [15:0] rem_idle_q;
  logic [15:0] sd_ctrl_q;
  logic [15:0] sd_stat_q;
  logic [15:0] idle_stat_q;
  logic        ack_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        force_q;
  logic        wr_go;
  logic        rd_go;
  logic        in_idle;
  logic        past_sd_q;
  logic [LANES-1:0] det_d;

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // one access per request, ack drops the cycle after it is given
  assign wr_go   = wb_cyc_in && wb_stb_in && !ack_q && wb_we_in;
  assign rd_go   = wb_cyc_in && wb_stb_in && !ack_q && !wb_we_in;
  assign in_idle = (phy_state_in == PHY_STATE_IDLE);

  // ---------------------------------------------------------------
  // bus handshake
  // ---------------------------------------------------------------
  // single wait-state answer, ack the cycle after the request; unmapped addresses still ack with zero
  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q   <= wb_cyc_in && wb_stb_in && !ack_q;
      rdata_q <= rd_go ? rdata_d : 32'h0000_0000;
    end
  end

  assign wb_ack_out = ack_q;
  assign wb_dat_out = rdata_q;

  // ---------------------------------------------------------------
  // per-lane detect result after forcing
  // ---------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < LANES; i++)
    begin
      // (R10) detect forcing modes
      case (ctrl_q[i][1:0])
        SDM_FORCE_OFF: det_d[i] = 1'b0;
        SDM_FORCE_ON:  det_d[i] = 1'b1;
        default:       det_d[i] = lane_in[i].raw_detect;
      endcase
      // (R19) force bit overrides
      if (force_q)
      begin
        det_d[i] = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // per-lane registers
  // ---------------------------------------------------------------
  // control words keep every written bit, reserved ones included
  always_ff @(posedge clk_sys_in)
  begin
    for (int i = 0; i < LANES; i++)
    begin
      if (!resetn_in)
      begin
        margin_q[i] <= MARGIN_RST;
        ctrl_q[i]   <= LANE_CTRL_RST;
      end
      else if (wr_go && wb_adr_in == 8'(i * LANE_STRIDE + OFS_MARGIN))
      begin
        margin_q[i] <= merge(margin_q[i], wb_dat_in, wb_sel_in);
      end
      // (R23) reserved control preserved
      else if (wr_go && wb_adr_in == 8'(i * LANE_STRIDE + OFS_CTRL))
      begin
        ctrl_q[i] <= merge(ctrl_q[i], wb_dat_in, wb_sel_in);
      end
    end
  end

  // lane status snapshot, rebuilt every cycle from receive logic
  always_ff @(posedge clk_sys_in)
  begin
    for (int i = 0; i < LANES; i++)
    begin
      if (!resetn_in)
      begin
        status_q[i] <= 32'h0000_0000;
      end
      else
      begin
        status_q[i] <= 32'h0000_0000;
        // (R3) cleared while quiescent
        if (!in_idle)
        begin
          status_q[i][0] <= det_d[i];
          // (R4) polarity report
          case (ctrl_q[i][3:2])
            POL_FIX_NORM: status_q[i][1] <= 1'b0;
            POL_FIX_INV:  status_q[i][1] <= 1'b1;
            default:      status_q[i][1] <= lane_in[i].polarity;
          endcase
          // (R5) clock recovery lock
          status_q[i][2] <= lane_in[i].cdr_lock;
          // (R6) alignment and training errors
          status_q[i][4] <= lane_in[i].aligned;
          status_q[i][5] <= lane_in[i].train_err;
        end
        // (R5) equalization completed
        status_q[i][3] <= lane_in[i].eq_done;
        // (R7) self-test ratio when enabled
        if (selftest_en_in)
        begin
          status_q[i][ST_BUILT_IN_LINK_SELF_TEST +: 4] <= lane_in[i].selftest_ber;
        end
        // (R8) requested remote cursors
        status_q[i][ST_PRE +: 4]   <= lane_in[i].req_pre;
        status_q[i][ST_POST +: 4]  <= lane_in[i].req_post;
        status_q[i][ST_SWING +: 4] <= lane_in[i].req_swing;
        // (R9) remote change request
        status_q[i][ST_CHANGE]     <= lane_in[i].req_change;
      end
    end
  end

  // lane settings driven out from flops
  always_ff @(posedge clk_sys_in)
  begin
    for (int i = 0; i < LANES; i++)
    begin
      if (!resetn_in)
      begin
        lane_cfg_out[i] <= '0;
      end
      else
      begin
        lane_cfg_out[i].detect_mode   <= ctrl_q[i][1:0];
        // (R11) polarity selection
        lane_cfg_out[i].polarity_mode <= ctrl_q[i][3:2];
        // (R12) peaking in dB
        lane_cfg_out[i].peaking       <= ctrl_q[i][8:4];
        lane_cfg_out[i].detected      <= det_d[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // idle power down
  // ---------------------------------------------------------------
  // in-band writes cannot reach bit 0, so the far end cannot park us
  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      idle_ctrl_q <= IDLE_CTRL_RST;
      rem_idle_q  <= REM_IDLE_RST;
    end
    else if (wr_go && wb_adr_in == OFS_IDLE_CTRL)
    begin
      idle_ctrl_q[15:1] <= 15'(merge({16'h0000, idle_ctrl_q}, wb_dat_in, wb_sel_in) >> 1);
      // (R13) sideband-only power down
      if (sideband_in && wb_sel_in[0])
      begin
        idle_ctrl_q[0] <= wb_dat_in[0];
      end
    end
    else if (wr_go && wb_adr_in == OFS_REM_IDLE)
    begin
      rem_idle_q <= 16'(merge({16'h0000, rem_idle_q}, wb_dat_in, wb_sel_in));
    end
  end

  // power down output follows the bit in any state; status reports it only while quiescent
  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      idle_stat_q    <= 16'h0000;
      power_down_out <= 1'b0;
    end
    else
    begin
      // (R14) mode in effect status
      idle_stat_q    <= {15'h0000, idle_ctrl_q[0] && FPD_SUPPORT && in_idle};
      power_down_out <= idle_ctrl_q[0] && FPD_SUPPORT;
    end
  end

  // ---------------------------------------------------------------
  // signal detect state
  // ---------------------------------------------------------------
  // force bit is write-only: a one-cycle pulse, never stored for reads
  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      sd_ctrl_q <= SD_CTRL_RST;
      force_q   <= 1'b0;
    end
    else
    begin
      // (R19) write-only force pulse
      force_q <= wr_go && wb_adr_in == OFS_SD_CTRL && wb_sel_in[0] && wb_dat_in[0];
      if (wr_go && wb_adr_in == OFS_SD_CTRL)
      begin
        // (R20) (R21) (R22) timer, header and scrambler fields
        sd_ctrl_q <= 16'(merge({16'h0000, sd_ctrl_q}, wb_dat_in, wb_sel_in)) & 16'hFFFE;
      end
    end
  end

  // error and reversal bits held at zero until training reaches the detect state
  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      sd_stat_q <= 16'h0000;
      past_sd_q <= 1'b0;
    end
    else
    begin
      past_sd_q <= sd_reached_in && !in_idle;
      sd_stat_q <= 16'h0000;
      // (R16) OR of lane results
      sd_stat_q[0] <= !in_idle && (|det_d);
      // (R17) unresolved width error
      sd_stat_q[1] <= past_sd_q && (|det_d) && sd_width_fail_in;
      // (R18) lane reversal report
      sd_stat_q[2] <= past_sd_q && sd_reversal_in;
    end
  end

  // detect settings out
  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      detect_cfg_out <= '0;
    end
    else
    begin
      detect_cfg_out.send_timer      <= sd_ctrl_q[SDC_SEND +: 2];
      detect_cfg_out.idle_timer      <= sd_ctrl_q[SDC_IDLE +: 2];
      detect_cfg_out.trans_timer     <= sd_ctrl_q[SDC_TRANS +: 2];
      detect_cfg_out.repeat_count    <= sd_ctrl_q[SDC_REPEAT +: 2];
      detect_cfg_out.header_freq     <= sd_ctrl_q[SDC_FREQ +: 2];
      // (R22) headers reset scrambler
      detect_cfg_out.scrambler_reset <= sd_ctrl_q[SDC_SCRAM];
      detect_cfg_out.force_detect    <= force_q;
    end
  end

  // ---------------------------------------------------------------
  // read decode
  // ---------------------------------------------------------------
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    // (R23) unlisted bits read zero
    if (wb_adr_in == OFS_IDLE_STAT)
    begin
      rdata_d = {16'h0000, idle_stat_q};
    end
    else if (wb_adr_in == OFS_IDLE_CTRL)
    begin
      rdata_d = {16'h0000, idle_ctrl_q};
    end
    else if (wb_adr_in == OFS_IDLE_CAP)
    begin
      // (R15) exit latency code
      rdata_d = {29'h0000_0000, FPD_EXIT, FPD_SUPPORT};
    end
    else if (wb_adr_in == OFS_REM_IDLE)
    begin
      rdata_d = {16'h0000, rem_idle_q};
    end
    else if (wb_adr_in == OFS_SD_STAT)
    begin
      rdata_d = {16'h0000, sd_stat_q};
    end
    else if (wb_adr_in == OFS_SD_CTRL)
    begin
      rdata_d = {16'h0000, sd_ctrl_q};
    end
    else
    begin
      for (int i = 0; i < LANES; i++)
      begin
        if (wb_adr_in == 8'(i * LANE_STRIDE + OFS_MARGIN))
        begin
          rdata_d = {8'h00, lane_in[i].margin_ber, 1'b0, MRG_SUPPORT, margin_q[i][15:0]};
          // (R1) unsupported offset flag
          rdata_d[MRG_CFG_BAD] = lane_in[i].margin_bad;
          // (R2) margining result code
          rdata_d[MRG_BER_LSB +: 4] = lane_in[i].margin_ber;
        end
        else if (wb_adr_in == 8'(i * LANE_STRIDE + OFS_STATUS))
        begin
          rdata_d = status_q[i];
        end
        else if (wb_adr_in == 8'(i * LANE_STRIDE + OFS_CTRL))
        begin
          rdata_d = ctrl_q[i];
        end
      end
    end
  end

endmodule

/* rtl/phylsr_pkg.sv */
// constants and carrier types for the lane state register bank
package phylsr_pkg;

  // ---------------------------------------------------------------
  // geometry and bus map
  // ---------------------------------------------------------------
  localparam int         LANES          = 4;
  localparam int         AW             = 8;
  localparam logic [7:0] LANE_STRIDE    = 8'h10;
  localparam logic [7:0] OFS_MARGIN     = 8'h00;
  localparam logic [7:0] OFS_STATUS     = 8'h04;
  localparam logic [7:0] OFS_CTRL       = 8'h08;
  localparam logic [7:0] OFS_IDLE_STAT  = 8'h40;
  localparam logic [7:0] OFS_IDLE_CTRL  = 8'h44;
  localparam logic [7:0] OFS_IDLE_CAP   = 8'h48;
  localparam logic [7:0] OFS_REM_IDLE   = 8'h4C;
  localparam logic [7:0] OFS_SD_STAT    = 8'h50;
  localparam logic [7:0] OFS_SD_CTRL    = 8'h54;

  // ---------------------------------------------------------------
  // codes and reset values
  // ---------------------------------------------------------------
  localparam logic [3:0]  PHY_STATE_IDLE = 4'h0;
  localparam logic [1:0]  SDM_FORCE_OFF  = 2'h2;
  localparam logic [1:0]  SDM_FORCE_ON   = 2'h3;
  localparam logic [1:0]  POL_FIX_NORM   = 2'h0;
  localparam logic [1:0]  POL_FIX_INV    = 2'h1;
  localparam logic [31:0] LANE_CTRL_RST  = 32'h0000_0018;
  localparam logic [31:0] MARGIN_RST     = 32'h0000_0000;
  localparam logic [15:0] IDLE_CTRL_RST  = 16'h0000;
  localparam logic [15:0] REM_IDLE_RST   = 16'h0000;
  localparam logic [15:0] SD_CTRL_RST    = 16'h08D4;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int MRG_CFG_BAD = 19;
  localparam int MRG_BER_LSB = 20;
  localparam int ST_BUILT_IN_LINK_SELF_TEST    = 8;
  localparam int ST_PRE      = 16;
  localparam int ST_POST     = 20;
  localparam int ST_SWING    = 24;
  localparam int ST_CHANGE   = 28;
  localparam int SDC_SEND    = 1;
  localparam int SDC_IDLE    = 3;
  localparam int SDC_TRANS   = 5;
  localparam int SDC_REPEAT  = 7;
  localparam int SDC_FREQ    = 9;
  localparam int SDC_SCRAM   = 11;

  // per-lane status from the receive logic
  typedef struct packed {
    logic       raw_detect;
    logic       polarity;
    logic       cdr_lock;
    logic       eq_done;
    logic       aligned;
    logic       train_err;
    logic       margin_bad;
    logic [3:0] margin_ber;
    logic [3:0] selftest_ber;
    logic [3:0] req_pre;
    logic [3:0] req_post;
    logic [3:0] req_swing;
    logic       req_change;
  } phylsr_lane_in_t;

  // per-lane settings to the receive logic
  typedef struct packed {
    logic [1:0] detect_mode;
    logic [1:0] polarity_mode;
    logic [4:0] peaking;
    logic       detected;
  } phylsr_lane_cfg_t;

  // signal detect state settings
  typedef struct packed {
    logic [1:0] send_timer;
    logic [1:0] idle_timer;
    logic [1:0] trans_timer;
    logic [1:0] repeat_count;
    logic [1:0] header_freq;
    logic       scrambler_reset;
    logic       force_detect;
  } phylsr_detect_cfg_t;

endpackage

/* bench/phylsr_monitor.sv */
// port checker for the lane state register bank
`timescale 1ns/1ps

module phylsr_monitor
  import phylsr_pkg::*;
(
  // clock, reset and wishbone
  input wire logic                         clk_sys_in,
  input wire logic                         resetn_in,
  input wire logic                         wb_cyc_in,
  input wire logic                         wb_stb_in,
  input wire logic                         wb_we_in,
  input wire logic [AW-1:0]                wb_adr_in,
  input wire logic [3:0]                   wb_sel_in,
  input wire logic [31:0]                  wb_dat_in,
  input wire logic [31:0]                  wb_dat_out,
  input wire logic                         wb_ack_out,
  // side band and settings
  input wire logic                         sideband_in,
  input wire phylsr_lane_cfg_t [LANES-1:0] lane_cfg_out,
  input wire phylsr_detect_cfg_t           detect_cfg_out,
  input wire logic                         power_down_out
);
  // ---------------------------------------------------------------
  // sequences and properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!resetn_in);

  // request seen with no answer pending
  sequence s_taken;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence s_force_wr;
    s_taken ##0 (wb_we_in && wb_adr_in == OFS_SD_CTRL && wb_sel_in[0] && wb_dat_in[0]);
  endsequence
  // mode and registered result flop on the same edge from the same control word
  sequence s_forced_on;
    (lane_cfg_out[0].detect_mode == SDM_FORCE_ON) [*3];
  endsequence

  AST_ACK_LAT: assert property (s_taken |=> wb_ack_out)
    else $error("ack missing after request");
  AST_ACK_ONE: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property ($rose(wb_ack_out) |-> $past(wb_cyc_in && wb_stb_in))
    else $error("ack without request");
  AST_DAT_IDLE: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
    else $error("read data outside ack");
  AST_PD_SIDEBAND: assert property ($rose(power_down_out) |-> $past(sideband_in) || $past(sideband_in, 2))
    else $error("power down set in band");
  AST_RST_LANE: assert property ($rose(resetn_in) |=> lane_cfg_out[0].polarity_mode == 2'h2
    && lane_cfg_out[0].peaking == 5'h01 && lane_cfg_out[0].detect_mode == 2'h0)
    else $error("lane settings not at reset value");
  AST_RST_DETECT: assert property ($rose(resetn_in) |=> detect_cfg_out == 12'b10_10_10_01_00_1_0)
    else $error("detect settings not at reset value");
  AST_FORCE_PULSE: assert property (s_force_wr |-> ##2 detect_cfg_out.force_detect ##1 !detect_cfg_out.force_detect)
    else $error("force pulse missing");
  AST_FORCED_ON: assert property (s_forced_on |-> lane_cfg_out[0].detected)
    else $error("forced lane not detected");
endmodule

/* bench/phylsr_lane_model.sv */
// far side lane receive model driving per-lane status
`timescale 1ns/1ps

module phylsr_lane_model
  import phylsr_pkg::*;
(
  // clock and load request
  input  wire logic                   clk_sys_in,
  input  wire logic                   load_in,
  input  wire logic [1:0]             lane_sel_in,
  input  wire logic [31:0]            rnd_in,
  // per-lane status toward the bank
  output phylsr_lane_in_t [LANES-1:0] lane_out
);
  // ---------------------------------------------------------------
  // status generation
  // ---------------------------------------------------------------
  // legal code ranges
  function automatic phylsr_lane_in_t fold(input logic [31:0] r);
    phylsr_lane_in_t s;
    s = r[27:0];
    s.margin_ber = 4'(r[3:0] % 4'd13);
    s.selftest_ber = 4'(r[7:4] % 4'd9);
    s.req_pre = {2'h0, r[9:8]};
    s.req_post = 4'(r[13:10] % 4'd6);
    s.req_swing = 4'(r[17:14] % 4'd7);
    return s;
  endfunction

  // lanes idle quiet until loaded; one lane updates per cycle
  initial
  begin
    lane_out = '0;
  end
  always @(posedge clk_sys_in)
  begin
    if (load_in)
      lane_out[lane_sel_in] <= fold(rnd_in);
  end
endmodule

/* bench/phylsr_top_tb.sv */
// self-checking bench for the lane state register bank
`timescale 1ns/1ps

module phylsr_top_tb
  import phylsr_pkg::*;
;
  logic                         clk_sys_in = 1'b0;
  logic                         resetn_in = 1'b0;
  logic                         wb_cyc_in = 1'b0;
  logic                         wb_stb_in = 1'b0;
  logic                         wb_we_in = 1'b0;
  logic [7:0]                   wb_adr_in = 8'h00;
  logic [3:0]                   wb_sel_in = 4'h0;
  logic [31:0]                  wb_dat_in = 32'h0;
  logic [31:0]                  wb_dat_out;
  logic                         wb_ack_out;
  logic                         sideband_in = 1'b0;
  logic [3:0]                   phy_state_in = 4'h0;
  logic                         selftest_en_in = 1'b0;
  logic                         sd_reached_in = 1'b0;
  logic                         sd_width_fail_in = 1'b0;
  logic                         sd_reversal_in = 1'b0;
  logic                         load_in = 1'b0;
  logic [1:0]                   lane_sel_in = 2'h0;
  logic [31:0]                  rnd_in = 32'h0;
  phylsr_lane_in_t [LANES-1:0]  lane_in;
  phylsr_lane_cfg_t [LANES-1:0] lane_cfg_out;
  phylsr_detect_cfg_t           detect_cfg_out;
  logic                         power_down_out;
  int                           n_errors = 0;
  int                           cmp_count = 0;

  initial
  begin
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end

  phylsr_top dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
    .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .sideband_in(sideband_in), .phy_state_in(phy_state_in),
    .selftest_en_in(selftest_en_in), .sd_reached_in(sd_reached_in), .sd_width_fail_in(sd_width_fail_in),
    .sd_reversal_in(sd_reversal_in), .lane_in(lane_in), .lane_cfg_out(lane_cfg_out),
    .detect_cfg_out(detect_cfg_out), .power_down_out(power_down_out));
  phylsr_lane_model far (.clk_sys_in(clk_sys_in), .load_in(load_in), .lane_sel_in(lane_sel_in),
    .rnd_in(rnd_in), .lane_out(lane_in));

  // ---------------------------------------------------------------
  // tasks and expectations
  // ---------------------------------------------------------------
  task automatic end_of_test();
    $display("mismatches %0d of %0d compares", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // one classic cycle; a lost ack ends the run
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] q);
    int n;
    @(posedge clk_sys_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= w;
    wb_adr_in <= a;
    wb_dat_in <= d;
    wb_sel_in <= s;
    n = 0;
    do
    begin
      @(posedge clk_sys_in);
      n++;
    end
    while (wb_ack_out !== 1'b1 && n < 16);
    q = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    if (wb_ack_out !== 1'b1)
    begin
      n_errors++;
      end_of_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hF, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hF, q);
    cmp(q, e);
  endtask

  task automatic load_lanes();
    for (int i = 0; i < LANES; i++)
    begin
      @(posedge clk_sys_in);
      load_in <= 1'b1;
      lane_sel_in <= 2'(i);
      rnd_in <= $urandom();
    end
    @(posedge clk_sys_in);
    load_in <= 1'b0;
  endtask

  // lane status word as software should see it
  function automatic logic [31:0] exp_stat(input phylsr_lane_in_t l, input logic [31:0] c,
                                           input logic idle, input logic en);
    logic det;
    logic pol;
    logic g;
    det = (c[1:0] == SDM_FORCE_ON) ? 1'b1 : (c[1:0] == SDM_FORCE_OFF) ? 1'b0 : l.raw_detect;
    pol = (c[3:2] == POL_FIX_NORM) ? 1'b0 : (c[3:2] == POL_FIX_INV) ? 1'b1 : l.polarity;
    g = !idle;
    return {3'h0, l.req_change, l.req_swing, l.req_post, l.req_pre, 4'h0, en ? l.selftest_ber : 4'h0,
            2'h0, g & l.train_err, g & l.aligned, l.eq_done, g & l.cdr_lock, g & pol, g & det};
  endfunction

  initial
  begin
    logic [31:0] c [LANES];
    logic [15:0] m [LANES];
    logic [31:0] r;
    logic [31:0] q;
    logic [7:0]  b;
    logic        orv;
    logic        idle;
    r = $urandom(32'hd7726dd3);
    repeat (3) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    // reset values and unmapped holes
    for (int i = 0; i < LANES; i++)
      rd(8'(i) * LANE_STRIDE + OFS_CTRL, LANE_CTRL_RST);
    rd(OFS_SD_CTRL, {16'h0, SD_CTRL_RST});
    rd(OFS_IDLE_CAP, 32'h1);
    rd(OFS_REM_IDLE, {16'h0, REM_IDLE_RST});
    rd(8'h0C, 32'h0);
    rd(8'h5C, 32'h0);
    // random lane status against control modes and link state
    for (int it = 0; it < 24; it++)
    begin
      load_lanes();
      idle = (it % 4 == 1);
      phy_state_in <= idle ? PHY_STATE_IDLE : 4'($urandom_range(15, 1));
      selftest_en_in <= 1'($urandom());
      sd_reached_in <= 1'($urandom());
      sd_width_fail_in <= 1'($urandom());
      sd_reversal_in <= 1'($urandom());
      for (int i = 0; i < LANES; i++)
      begin
        b = 8'(i) * LANE_STRIDE;
        r = $urandom();
        c[i] = {r[31:9], 5'(5'd1 + r[8:4] % 5'd31), 2'(r[3:2] % 2'd3), (r[1:0] == 2'h1) ? 2'h0 : r[1:0]};
        wr(b + OFS_CTRL, c[i]);
        rd(b + OFS_CTRL, c[i]);
        r = $urandom();
        m[i] = r[15:0];
        wr(b + OFS_MARGIN, r);
      end
      orv = 1'b0;
      for (int i = 0; i < LANES; i++)
      begin
        b = 8'(i) * LANE_STRIDE;
        r = exp_stat(lane_in[i], c[i], idle, selftest_en_in);
        orv = orv | r[0];
        rd(b + OFS_STATUS, r);
        rd(b + OFS_MARGIN, {8'h0, lane_in[i].margin_ber, lane_in[i].margin_bad, 3'h0, m[i]});
      end
      rd(OFS_SD_STAT, {29'h0, !idle & sd_reached_in & sd_reversal_in, sd_reached_in & sd_width_fail_in & orv, orv});
    end
    // byte lane write only touches its byte
    bus(1'b1, OFS_CTRL, 32'hFFFF_FFFF, 4'h2, q);
    rd(OFS_CTRL, c[0] | 32'h0000_FF00);
    // power down reachable only from the sideband
    phy_state_in <= PHY_STATE_IDLE;
    wr(OFS_IDLE_CTRL, 32'h1);
    rd(OFS_IDLE_CTRL, 32'h0);
    cmp({31'h0, power_down_out}, 32'h0);
    sideband_in <= 1'b1;
    wr(OFS_IDLE_CTRL, 32'hFFFF);
    rd(OFS_IDLE_CTRL, 32'hFFFF);
    rd(OFS_IDLE_STAT, 32'h1);
    cmp({31'h0, power_down_out}, 32'h1);
    sideband_in <= 1'b0;
    phy_state_in <= 4'h3;
    wr(OFS_IDLE_CTRL, 32'hFFFE);
    rd(OFS_IDLE_CTRL, 32'hFFFF);
    rd(OFS_IDLE_STAT, 32'h0);
    sideband_in <= 1'b1;
    wr(OFS_IDLE_CTRL, 32'h0);
    rd(OFS_IDLE_STAT, 32'h0);
    // remote capability and detect settings with a force
    r = $urandom();
    wr(OFS_REM_IDLE, r);
    rd(OFS_REM_IDLE, {16'h0, r[15:0]});
    r = $urandom();
    r[0] = 1'b1;
    r[8] = r[8] & ~r[7];
    wr(OFS_SD_CTRL, r);
    rd(OFS_SD_CTRL, {16'h0, r[15:1], 1'b0});
    cmp({20'h0, detect_cfg_out}, {20'h0, r[2:1], r[4:3], r[6:5], r[8:7], r[10:9], r[11], 1'b0});
    end_of_test();
  end
endmodule

bind phylsr_top phylsr_monitor mon (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
  .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .sideband_in(sideband_in),
  .lane_cfg_out(lane_cfg_out), .detect_cfg_out(detect_cfg_out), .power_down_out(power_down_out));
